/* hw/ocr_stage_timing.v */
// four-stage overcurrent pick-up, release and operate timing with apb registers
`timescale 1ns/1ps
`include "ocr_defines.vh"
module ocr_stage_timing #(
    parameter W = 16,
    parameter TICK_CYCLES = `OCR_TICK_CYCLES
) (
    input wire pclk, // bus and logic clock
    input wire presetn, // async reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error, unmapped address
    input wire [3*W-1:0] meas_rms, // fundamental rms, phases c,b,a
    input wire [3*W-1:0] meas_trms, // true rms, phases c,b,a
    input wire [3*W-1:0] meas_pp, // peak-to-peak, phases c,b,a
    input wire group_sel, // active setting group
    input wire comm_wr, // comm bus pick-up write strobe
    input wire [1:0] comm_stage, // comm bus target stage
    input wire comm_group, // comm bus target group
    input wire [15:0] comm_level, // comm bus pick-up level
    output reg [3:0] start_o, // stage start
    output reg [3:0] trip_o, // stage trip
    output reg [3:0] blocked_o, // stage blocked
    output reg [11:0] phase_start_o, // per stage c,b,a start
    output reg [11:0] phase_trip_o, // per stage c,b,a trip
    output reg irq // level interrupt
);
// ==========================================================
// helpers
function [3*W-1:0] sel_mag;
    input [1:0] s;
    input [3*W-1:0] r, t, p;
    begin
        case (s)
            `OCR_MEAS_TRMS: sel_mag = t;
            `OCR_MEAS_PP: sel_mag = p;
            default: sel_mag = r;
        endcase
    end
endfunction
// returns {blocked, trip c,b,a, start c,b,a}
function [6:0] force_dec;
    input [4:0] f;
    begin
        case (f)
            `OCR_F_START: force_dec = 7'h07;
            `OCR_F_TRIP: force_dec = 7'h3f;
            `OCR_F_BLOCKED: force_dec = 7'h40;
            `OCR_F_SA: force_dec = 7'h01;
            `OCR_F_SB: force_dec = 7'h02;
            `OCR_F_SC: force_dec = 7'h04;
            `OCR_F_TA: force_dec = 7'h09;
            `OCR_F_TB: force_dec = 7'h12;
            `OCR_F_TC: force_dec = 7'h24;
            `OCR_F_SAB: force_dec = 7'h03;
            `OCR_F_SBC: force_dec = 7'h06;
            `OCR_F_SCA: force_dec = 7'h05;
            `OCR_F_SABC: force_dec = 7'h07;
            `OCR_F_TAB: force_dec = 7'h1b;
            `OCR_F_TBC: force_dec = 7'h36;
            `OCR_F_TCA: force_dec = 7'h2d;
            `OCR_F_TABC: force_dec = 7'h3f;
            default: force_dec = 7'h00;
        endcase
    end
endfunction
// ==========================================================
// apb decode; one wait state, write lands on the ready edge
wire acc = psel & penable & pready;
wire wr = acc & pwrite;
wire st_hit = paddr[11:7] == 5'h01;
wire [1:0] s_idx = paddr[6:5];
wire [2:0] r_idx = paddr[4:2];
wire st_ok = st_hit & (r_idx <= `OCR_I_STAT) & (paddr[1:0] == 2'h0);
wire gl_ok = (paddr[11:4] == 8'h00) & (paddr[1:0] == 2'h0);
reg [1:0] ctrl;
reg [7:0] istat;
reg [7:0] imask;
wire [127:0] cfg_v;
wire [63:0] pk0_v;
wire [63:0] pk1_v;
wire [63:0] opd_v;
wire [63:0] rel_v;
wire [127:0] sts_v;
wire [3:0] st_i;
wire [3:0] tr_i;
wire [3:0] bk_i;
wire [11:0] pst_i;
wire [11:0] ptr_i;
// ==========================================================
// 5 ms time base and measurement capture
reg [23:0] tcnt;
reg tick;
reg [3*W-1:0] m_rms, m_trms, m_pp;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tcnt <= 24'h000000;
        tick <= 1'b0;
        m_rms <= {3*W{1'b0}};
        m_trms <= {3*W{1'b0}};
        m_pp <= {3*W{1'b0}};
    end else begin
        tick <= 1'b0;
        if (tcnt >= TICK_CYCLES - 1) begin
            tcnt <= 24'h000000;
            tick <= 1'b1;
            m_rms <= meas_rms;
            m_trms <= meas_trms;
            m_pp <= meas_pp;
        end else begin
            tcnt <= tcnt + 24'h000001;
        end
    end
end
// ==========================================================
// stages
genvar g;
generate
for (g = 0; g < 4; g = g + 1) begin : stg
    reg [31:0] cfg;
    reg [15:0] pk0, pk1, opd, reld, opc, relc;
    reg rel, st, tr, bk;
    reg [2:0] pst, ptr;
    wire wsel = wr & st_ok & (s_idx == g);
    wire cw = comm_wr & (comm_stage == g) & cfg[`OCR_CFG_BUS];
    // the node mode field only counts while individual mode setting is allowed
    wire [2:0] ln = ctrl[`OCR_CTRL_LNEN] ? cfg[`OCR_CFG_LN+:3] : `OCR_LN_ON;
    wire off = ln == `OCR_LN_OFF;
    wire blkm = (ln == `OCR_LN_BLK) | (ln == `OCR_LN_TBLK);
    wire [3*W-1:0] mag = sel_mag(cfg[`OCR_CFG_MEAS+:2], m_rms, m_trms, m_pp);
    wire [15:0] pk = group_sel ? pk1 : pk0;
    wire [2:0] ph;
    genvar p;
    for (p = 0; p < 3; p = p + 1) begin : phs
        assign ph[p] = mag[W*p+:W] > pk[W-1:0];
    end
    wire pick = (|ph) & ~off & ~blkm;
    wire [16:0] op_nx = {1'b0, opc} + 17'h00001;
    wire [16:0] rl_nx = {1'b0, relc} + 17'h00001;
    wire instant = $signed(opd) <= 0;
    wire [6:0] fd = ctrl[`OCR_CTRL_FEN] ? force_dec(cfg[`OCR_CFG_FORCE+:5]) : 7'h00;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `OCR_CFG_RESET;
            pk0 <= `OCR_PK_RESET;
            pk1 <= `OCR_PK_RESET;
            opd <= 16'h0000;
            reld <= `OCR_REL_DEF;
            opc <= 16'h0000;
            relc <= 16'h0000;
            {rel, st, tr, bk} <= 4'h0;
            pst <= 3'h0;
            ptr <= 3'h0;
        end else begin
            // general settings live outside the group banks, so group switching leaves them
            if (wsel && r_idx == `OCR_I_CFG) cfg <= pwdata;
            if (wsel && r_idx == `OCR_I_OPD) opd <= pwdata[15:0];
            if (wsel && r_idx == `OCR_I_REL) reld <= pwdata[15:0];
            if (wsel && r_idx == `OCR_I_PK0) pk0 <= pwdata[15:0];
            else if (cw && !comm_group) pk0 <= comm_level;
            if (wsel && r_idx == `OCR_I_PK1) pk1 <= pwdata[15:0];
            else if (cw && comm_group) pk1 <= comm_level;
            if (off) begin
                opc <= 16'h0000;
                relc <= 16'h0000;
                {rel, st, tr, bk} <= 4'h0;
                pst <= 3'h0;
                ptr <= 3'h0;
            end else if (tick) begin
                bk <= (|ph) & blkm;
                if (pick) begin
                    rel <= 1'b0;
                    relc <= 16'h0000;
                    st <= 1'b1;
                    pst <= ph;
                    if (instant || op_nx >= {1'b0, opd}) begin
                        tr <= 1'b1;
                        ptr <= ph;
                    end else begin
                        opc <= op_nx[15:0];
                    end
                end else begin
                    tr <= 1'b0;
                    ptr <= 3'h0;
                    if (st && !cfg[`OCR_CFG_DLY]) begin
                        st <= 1'b0;
                        pst <= 3'h0;
                        opc <= 16'h0000;
                        relc <= 16'h0000;
                    end else if (st) begin
                        rel <= 1'b1;
                        relc <= rl_nx[15:0];
                        if (!cfg[`OCR_CFG_RST])
                            opc <= 16'h0000;
                        else if (cfg[`OCR_CFG_CONT] && opc != 16'h0000)
                            opc <= opc - 16'h0001;
                        // otherwise opc stays frozen through the release
                        if (rl_nx >= {1'b0, reld}) begin
                            st <= 1'b0;
                            rel <= 1'b0;
                            pst <= 3'h0;
                            relc <= 16'h0000;
                            opc <= 16'h0000;
                        end
                    end
                end
            end
        end
    end
    // forced status adds to the measured one, it never masks it
    assign st_i[g] = st | (|fd[2:0]) | (|fd[5:3]);
    assign tr_i[g] = tr | (|fd[5:3]);
    assign bk_i[g] = bk | fd[6];
    assign pst_i[3*g+:3] = pst | fd[2:0];
    assign ptr_i[3*g+:3] = ptr | fd[5:3];
    assign cfg_v[32*g+:32] = cfg;
    assign pk0_v[16*g+:16] = pk0;
    assign pk1_v[16*g+:16] = pk1;
    assign opd_v[16*g+:16] = opd;
    assign rel_v[16*g+:16] = reld;
    assign sts_v[32*g+:32] = {12'h000, bk, rel, tr, st, opc};
end
endgenerate
// ==========================================================
// outputs, interrupts and apb answer
wire [7:0] ev = {trip_o ^ tr_i, start_o ^ st_i} & {tr_i, st_i};
reg [31:0] next_prdata;
always @* begin
    next_prdata = 32'h00000000;
    if (st_ok) begin
        case (r_idx)
            `OCR_I_CFG: next_prdata = cfg_v[32*s_idx+:32];
            `OCR_I_PK0: next_prdata = {16'h0000, pk0_v[16*s_idx+:16]};
            `OCR_I_PK1: next_prdata = {16'h0000, pk1_v[16*s_idx+:16]};
            `OCR_I_OPD: next_prdata = {16'h0000, opd_v[16*s_idx+:16]};
            `OCR_I_REL: next_prdata = {16'h0000, rel_v[16*s_idx+:16]};
            default: next_prdata = sts_v[32*s_idx+:32];
        endcase
    end else begin
        case (paddr[3:0])
            4'h0: next_prdata = {30'h00000000, ctrl};
            4'h4: next_prdata = {24'h000000, istat};
            4'h8: next_prdata = {24'h000000, imask};
            default: next_prdata = {20'h00000, blocked_o, trip_o, start_o};
        endcase
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        ctrl <= 2'h0;
        istat <= 8'h00;
        imask <= 8'h00;
        irq <= 1'b0;
        start_o <= 4'h0;
        trip_o <= 4'h0;
        blocked_o <= 4'h0;
        phase_start_o <= 12'h000;
        phase_trip_o <= 12'h000;
    end else begin
        pready <= psel & penable & ~pready;
        pslverr <= psel & penable & ~pready & ~(st_ok | gl_ok);
        prdata <= next_prdata;
        start_o <= st_i;
        trip_o <= tr_i;
        blocked_o <= bk_i;
        phase_start_o <= pst_i;
        phase_trip_o <= ptr_i;
        if (wr && gl_ok && paddr[3:0] == 4'h0) ctrl <= pwdata[1:0];
        if (wr && gl_ok && paddr[3:0] == 4'h8) imask <= pwdata[7:0];
        // a new event in the clearing cycle survives the write-one-to-clear
        if (wr && gl_ok && paddr[3:0] == 4'h4) istat <= (istat & ~pwdata[7:0]) | ev;
        else istat <= istat | ev;
        irq <= |(istat & imask);
    end
end
endmodule

/* include/ocr_defines.vh */
// constants and register map of the overcurrent stage timing block
// Behaviour
// - a negative or zero operating delay makes the stage trip at once
// - delayed release holds start for the release delay, else start drops at once
// - release delay counts 5 ms steps, default 60 ms, gap allowed between pick-ups
// - reset-after-release clears the counter at release end, else at drop-off
// - delayed release without reset-after-release clears the counter at drop-off
// - reset-after-release without continued calculation freezes the counter in release
// - continued calculation with reset-after-release decreases the counter in release, stopping at zero
// - continued calculation never trips unless pick-up returns within the release
// - with forcing enabled a forced status is applied, default normal
// - while forcing, measured currents still drive the stage as well
// - four independent stages decide from phase current magnitude
// - magnitude selector: fundamental rms default, true rms, or peak-to-peak
// - all three phase inputs of each magnitude update on a 5 ms tick
// - node mode on, blocked, test, test/blocked, off; settable only when allowed
// - comm bus pick-up changes accepted only when bus control is allowed
// - general settings are static and unaffected by setting group switching
`ifndef OCR_DEFINES_VH
`define OCR_DEFINES_VH
// ==========================================================
// timing
`define OCR_CLK_NS 50
`define OCR_TICK_NS 5000000
`define OCR_TICK_CYCLES (`OCR_TICK_NS / `OCR_CLK_NS)
`define OCR_STEP_MS 5
`define OCR_REL_DEF_MS 60
`define OCR_REL_DEF (`OCR_REL_DEF_MS / `OCR_STEP_MS)
// ==========================================================
// global registers
`define OCR_A_CTRL 8'h00
`define OCR_A_ISTAT 8'h04
`define OCR_A_IMASK 8'h08
`define OCR_A_OUT 8'h0c
// stage registers: base 0x80 + 0x20 * stage, word index below
`define OCR_I_CFG 3'h0
`define OCR_I_PK0 3'h1
`define OCR_I_PK1 3'h2
`define OCR_I_OPD 3'h3
`define OCR_I_REL 3'h4
`define OCR_I_STAT 3'h5
// ==========================================================
// fields
`define OCR_CTRL_FEN 0
`define OCR_CTRL_LNEN 1
`define OCR_CFG_DLY 0
`define OCR_CFG_RST 1
`define OCR_CFG_CONT 2
`define OCR_CFG_MEAS 4
`define OCR_CFG_LN 8
`define OCR_CFG_FORCE 16
`define OCR_CFG_BUS 24
`define OCR_CFG_RESET 32'h00000003
`define OCR_PK_RESET 16'h0078
// ==========================================================
// encodings
`define OCR_MEAS_RMS 2'h0
`define OCR_MEAS_TRMS 2'h1
`define OCR_MEAS_PP 2'h2
`define OCR_LN_ON 3'h0
`define OCR_LN_BLK 3'h1
`define OCR_LN_TEST 3'h2
`define OCR_LN_TBLK 3'h3
`define OCR_LN_OFF 3'h4
`define OCR_F_NORMAL 5'h00
`define OCR_F_START 5'h01
`define OCR_F_TRIP 5'h02
`define OCR_F_BLOCKED 5'h03
`define OCR_F_SA 5'h04
`define OCR_F_SB 5'h05
`define OCR_F_SC 5'h06
`define OCR_F_TA 5'h07
`define OCR_F_TB 5'h08
`define OCR_F_TC 5'h09
`define OCR_F_SAB 5'h0a
`define OCR_F_SBC 5'h0b
`define OCR_F_SCA 5'h0c
`define OCR_F_SABC 5'h0d
`define OCR_F_TAB 5'h0e
`define OCR_F_TBC 5'h0f
`define OCR_F_TCA 5'h10
`define OCR_F_TABC 5'h11
`endif

/* sim/ocr_chk.sv */
// port checker of the overcurrent stage timing block
`timescale 1ns/1ps
module ocr_chk (
    input wire pclk, // clock
    input wire presetn, // reset, active low
    input wire psel, // apb select
    input wire penable, // apb access
    input wire pready, // apb ready
    input wire pslverr, // apb error
    input wire [3:0] start_o, // stage start
    input wire [3:0] trip_o, // stage trip
    input wire [11:0] phase_start_o, // phase start
    input wire [11:0] phase_trip_o // phase trip
);
    // ==========
    // helpers
    wire [3:0] ps_any;
    assign ps_any = {|phase_start_o[11:9], |phase_start_o[8:6],
        |phase_start_o[5:3], |phase_start_o[2:0]};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    // ==========
    // properties
    a_rdy_timing: assert property (setup_s ##1 access_s |=> pready)
        else $error("ready late");
    a_rdy_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_rdy_idle: assert property (!(psel && penable) |=> !pready)
        else $error("ready without access");
    a_err_rdy: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rst_quiet: assert property ($rose(presetn) |-> (start_o | trip_o) == 4'h0)
        else $error("outputs set after reset");
    a_trip_start: assert property ((trip_o & ~start_o) == 4'h0)
        else $error("trip without start");
    a_phase_stage: assert property ((ps_any & ~start_o) == 4'h0)
        else $error("phase start without stage start");
    a_ptrip_pstart: assert property ((phase_trip_o & ~phase_start_o) == 12'h0)
        else $error("phase trip without phase start");
endmodule

/* sim/ocr_front.sv */
// measurement front end model feeding all three magnitudes
`timescale 1ns/1ps
module ocr_front #(
    parameter TK = 20
) (
    input wire pclk, // clock
    input wire [1:0] sel, // magnitude carrying the level
    input wire [15:0] lvl, // level on every phase
    output reg [47:0] rms = 48'h0, // fundamental rms
    output reg [47:0] trms = 48'h0, // true rms
    output reg [47:0] pp = 48'h0 // peak-to-peak
);
    // own phase, unrelated to the block's tick
    integer c = 7;
    always @(posedge pclk) begin
        c <= (c == TK - 1) ? 0 : c + 1;
        if (c == 0) begin
            rms <= (sel == 2'h0) ? {3{lvl}} : 48'h0;
            trms <= (sel == 2'h1) ? {3{lvl}} : 48'h0;
            pp <= (sel == 2'h2) ? {3{lvl}} : 48'h0;
        end
    end
endmodule

/* sim/test_ocr_stage_timing.sv */
// testbench of the overcurrent stage timing block
`timescale 1ns/1ps
`include "ocr_defines.vh"
module test_ocr_stage_timing;
    localparam TK = 20;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic er, group_sel = 1'h0, comm_wr = 1'h0, comm_group = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd, x;
    logic [1:0] comm_stage = 2'h0, sel = 2'h0;
    logic [15:0] comm_level = 16'h0, lvl = 16'h0;
    logic [2:0] fx [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    logic [2:0] fm [14] = '{1, 2, 4, 1, 2, 4, 3, 6, 5, 7, 3, 6, 5, 7};
    logic [1:0] nx [5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h0};
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [47:0] rms, trms, pp;
    wire [3:0] start_o, trip_o, blocked_o;
    wire [11:0] phase_start_o, phase_trip_o;
    integer miscompares = 0, n_checks = 0;
    always #25 pclk = ~pclk;
    ocr_stage_timing #(.TICK_CYCLES(TK)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .meas_rms(rms), .meas_trms(trms),
        .meas_pp(pp), .group_sel, .comm_wr, .comm_stage, .comm_group, .comm_level,
        .start_o, .trip_o, .blocked_o, .phase_start_o, .phase_trip_o, .irq);
    ocr_front #(.TK(TK)) front (.pclk, .sel, .lvl, .rms, .trms, .pp);
    // ==========
    // bus and check helpers
    function automatic [11:0] sa(input integer g, input integer i);
        sa = 12'h80 + g * 32 + i * 4;
    endfunction
    task automatic ab(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tk(input integer n);
        repeat (n * TK) @(posedge pclk);
    endtask
    task automatic cw;
        comm_stage <= 2'h3;
        comm_level <= 16'h0055;
        comm_wr <= 1'h1;
        @(posedge pclk);
        comm_wr <= 1'h0;
    endtask
    // ==========
    // scenarios
    task automatic t_regs;
        ab(1'h0, sa(0, `OCR_I_CFG), 32'h0);
        ck("cfg", `OCR_CFG_RESET, rd);
        ab(1'h0, sa(0, `OCR_I_REL), 32'h0);
        ck("rel", `OCR_REL_DEF, rd);
        ab(1'h1, 12'h040, 32'h0);
        ck("unmapped", 1'h1, er);
    endtask
    task automatic t_hold;
        ab(1'h1, sa(0, `OCR_I_OPD), 32'h64);
        lvl <= 16'h0100;
        tk(5);
        ck("start", 4'hf, start_o);
        ck("trip", 1'h0, trip_o[0]);
        lvl <= 16'h0;
        tk(3);
        ab(1'h0, sa(0, `OCR_I_STAT), 32'h0);
        x = rd;
        ck("counted", 1'h1, |x[15:0]);
        tk(3);
        ab(1'h0, sa(0, `OCR_I_STAT), 32'h0);
        ck("frozen", x[15:0], rd[15:0]);
        tk(4);
        ck("held", 1'h1, start_o[0]);
        tk(5);
        ck("released", 1'h0, start_o[0]);
        ab(1'h0, sa(0, `OCR_I_STAT), 32'h0);
        ck("cleared", 16'h0, rd[15:0]);
    endtask
    task automatic t_mode(input logic [31:0] cf);
        ab(1'h1, sa(0, `OCR_I_CFG), cf);
        lvl <= 16'h0100;
        tk(6);
        lvl <= 16'h0;
        // front end and block tick run on unrelated phases: allow two ticks of latency
        tk(3);
        ab(1'h0, sa(0, `OCR_I_STAT), 32'h0);
        x = rd;
        tk(1);
        ab(1'h0, sa(0, `OCR_I_STAT), 32'h0);
        if (cf == 32'h0)
            ck("instant", 1'h0, start_o[0]);
        else if (cf == 32'h1)
            ck("dropclr", 17'h10000, rd[16:0]);
        else
            ck("decrease", 1'h1, rd[15:0] < x[15:0]);
        tk(14);
        ck("notrip", 1'h0, trip_o[0]);
    endtask
    task automatic t_neg;
        ab(1'h1, sa(0, `OCR_I_OPD), 32'hfffe);
        lvl <= 16'h0100;
        tk(3);
        ck("instant trip", 1'h1, trip_o[0]);
        lvl <= 16'h0;
        tk(16);
    endtask
    task automatic t_force;
        ab(1'h1, `OCR_A_CTRL, 32'h1);
        for (int i = 0; i < 18; i++) begin
            ab(1'h1, sa(1, `OCR_I_CFG), 32'h3 | (i << 16));
            repeat (2) @(posedge pclk);
            if (i < 4)
                ck("force", fx[i], {blocked_o[1], trip_o[1], start_o[1]});
            else if (i inside {[7:9], [14:17]})
                ck("ftrip", fm[i - 4], phase_trip_o[5:3]);
            else
                ck("fstart", fm[i - 4], phase_start_o[5:3]);
        end
        ab(1'h1, sa(1, `OCR_I_CFG), 32'h3);
        lvl <= 16'h0100;
        tk(3);
        ck("measured", 1'h1, start_o[1]);
        lvl <= 16'h0;
        ab(1'h1, `OCR_A_CTRL, 32'h0);
        tk(16);
    endtask
    task automatic t_node;
        lvl <= 16'h0100;
        ab(1'h1, `OCR_A_CTRL, 32'h2);
        for (int m = 0; m < 5; m++) begin
            // instant release, so a blocking mode drops start at once
            ab(1'h1, sa(2, `OCR_I_CFG), 32'h2 | (m << 8));
            tk(2);
            ck("node", nx[m], {blocked_o[2], start_o[2]});
        end
        ab(1'h1, `OCR_A_CTRL, 32'h0);
        tk(2);
        ck("node ignored", 1'h1, start_o[2]);
        ab(1'h1, sa(2, `OCR_I_CFG), 32'h3);
        lvl <= 16'h0;
        tk(16);
    endtask
    task automatic t_meas;
        for (int m = 0; m < 3; m++) begin
            ab(1'h1, sa(3, `OCR_I_CFG), 32'h3 | (m << 4));
            sel <= 2'((m + 1) % 3);
            lvl <= 16'h0100;
            tk(2);
            ck("other mag", 1'h0, start_o[3]);
            sel <= 2'(m);
            tk(3);
            ck("chosen mag", 1'h1, start_o[3]);
            lvl <= 16'h0;
            tk(16);
        end
        sel <= 2'h0;
    endtask
    task automatic t_comm;
        ab(1'h1, sa(3, `OCR_I_CFG), 32'h3);
        cw;
        ab(1'h0, sa(3, `OCR_I_PK0), 32'h0);
        ck("bus off", `OCR_PK_RESET, rd);
        ab(1'h1, sa(3, `OCR_I_CFG), 32'h01000003);
        cw;
        ab(1'h0, sa(3, `OCR_I_PK0), 32'h0);
        ck("bus on", 32'h55, rd);
        group_sel <= 1'h1;
        ab(1'h0, sa(3, `OCR_I_CFG), 32'h0);
        ck("static", 32'h01000003, rd);
        group_sel <= 1'h0;
    endtask
    task automatic t_irq;
        ab(1'h1, `OCR_A_IMASK, 32'h1);
        ab(1'h1, `OCR_A_ISTAT, 32'hff);
        lvl <= 16'h0100;
        tk(3);
        ck("irq", 1'h1, irq);
        ab(1'h1, `OCR_A_ISTAT, 32'h1);
        repeat (2) @(posedge pclk);
        ck("irq clear", 1'h0, irq);
        ab(1'h0, `OCR_A_ISTAT, 32'h0);
        ck("istat", 8'hfe, rd[7:0]);
        lvl <= 16'h0;
        tk(16);
    endtask
    // ==========
    // run control
    task automatic wrap_up;
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_hold;
        t_mode(32'h1);
        t_mode(32'h7);
        t_mode(32'h0);
        t_neg;
        t_force;
        t_node;
        t_meas;
        t_comm;
        t_irq;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        wrap_up;
    end
endmodule
bind ocr_stage_timing ocr_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .start_o(start_o),
    .trip_o(trip_o), .phase_start_o(phase_start_o), .phase_trip_o(phase_trip_o));
